// [hdl/bcs_sequencer.sv]
// bcs_sequencer: switching sequencer, soft-start and protection logic
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ns
module bcs_sequencer
#(
   parameter int unsigned OCSET_CYCLES = bcs_pkg::OCSET_CYC,
   parameter int unsigned SS_CYCLES    = bcs_pkg::SS_CYC
)
(
   // clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      rst_b_i,
   // apb slave
   input  wire logic                      psel_i,
   input  wire logic                      penable_i,
   input  wire logic                      pwrite_i,
   input  wire logic [7:0]                paddr_i,
   input  wire logic [31:0]               pwdata_i,
   output logic      [31:0]               prdata_o,
   output logic                           pready_o,
   output logic                           pslverr_o,
   // sense comparators (asynchronous)
   input  wire logic                      phase_low_i,
   input  wire logic                      low_gate_low_i,
   input  wire logic                      oc_level1_i,
   input  wire logic                      oc_level2_i,
   input  wire logic                      ocset_clamp_i,
   input  wire logic                      output_undervolt_i,
   input  wire logic                      output_in_window_i,
   input  wire logic                      output_above_ref_i,
   // threshold sampling
   input  wire logic [bcs_pkg::DUTY_W-1:0] ocset_level_i,
   output logic                           trip_level_test_current_o,
   output logic [bcs_pkg::DUTY_W-1:0]     oc_threshold1_o,
   output logic [bcs_pkg::DUTY_W:0]       oc_threshold2_o,
   // power stage
   output logic                           high_side_switch_o,
   output logic                           low_side_switch_o,
   output logic [bcs_pkg::REF_W-1:0]      soft_ref_o,
   output logic                           output_good_flag_o,
   output logic                           overcurrent_trip_o,
   output logic                           output_undervolt_trip_o
);
   import bcs_pkg::*;

   localparam int unsigned SYNC_N = 7;
   localparam int unsigned CNT_W  = 32;
   localparam logic [REF_W-1:0] REF_FULL = {REF_W{1'b1}};

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [SYNC_N-1:0]  s1;
      logic [SYNC_N-1:0]  s2;
      logic [SYNC_N-1:0]  s3;
      logic [SYNC_N-1:0]  filt;
      bcs_state_t         state;
      bcs_phase_t         phase;
      logic [CNT_W-1:0]   tmr;
      logic [7:0]         sw_cnt;
      logic [7:0]         wdog;
      logic [2:0]         oc_cnt;
      logic               oc_seen;
      logic               ph_high;
      logic               hs_started;
      logic               ss_done;
      logic               oc_trip;
      logic               uv_trip;
      logic               good;
      logic               clamp_hit;
      logic [DUTY_W-1:0]  thresh;
      logic [REF_W-1:0]   ref_v;
      logic [DUTY_W-1:0]  duty;
      logic [31:0]        rdata;
   } bcs_regs_t;

   bcs_regs_t q_q;
   bcs_regs_t q_d;

   logic [SYNC_N-1:0] raw;
   logic              ph_low;
   logic              lg_low;
   logic              oc1;
   logic              oc2;
   logic              clamp;
   logic              uv;
   logic              in_win;
   logic              above;
   logic              cyc_end;
   logic              hs_req;
   logic              apb_acc;
   logic              oc_now;
   logic              ls_end;

   assign raw = {output_above_ref_i, output_in_window_i, output_undervolt_i,
                 ocset_clamp_i, oc_level2_i, oc_level1_i,
                 phase_low_i};
   assign ph_low  = q_q.filt[0];
   assign oc1     = q_q.filt[1];
   assign oc2     = q_q.filt[2];
   assign clamp   = q_q.filt[3];
   assign uv      = q_q.filt[4];
   assign in_win  = q_q.filt[5];
   assign above   = q_q.filt[6];
   assign apb_acc = psel_i & penable_i;

   // low-gate sense gets its own chain outside the struct vector
   logic lg_s1_q;
   logic lg_s2_q;
   logic lg_s3_q;
   logic lg_f_q;
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         lg_s1_q <= 1'b0;
         lg_s2_q <= 1'b0;
         lg_s3_q <= 1'b0;
         lg_f_q  <= 1'b0;
      end
      else
      begin
         lg_s1_q <= low_gate_low_i;
         lg_s2_q <= lg_s1_q;
         lg_s3_q <= lg_s2_q;
         if (lg_s2_q == lg_s3_q)
            lg_f_q <= lg_s3_q;
      end
   end
   assign lg_low = lg_f_q;

   // ****************************************
   // next-state logic
   // ****************************************
   always_comb
   begin
      q_d = q_q;
      // three flops, second and third agree
      q_d.s1 = raw;
      q_d.s2 = q_q.s1;
      q_d.s3 = q_q.s2;
      for (int i = 0; i < SYNC_N; i++)
      begin
         if (q_q.s2[i] == q_q.s3[i])
            q_d.filt[i] = q_q.s3[i];
      end

      cyc_end = (q_q.sw_cnt == 8'(SW_PERIOD_CYC - 1));
      q_d.sw_cnt = cyc_end ? 8'h00 : q_q.sw_cnt + 8'h01;
      hs_req = (q_q.sw_cnt < q_q.duty);

      unique case (q_q.state)
         BCS_OCSET:
         begin
            q_d.tmr = q_q.tmr + 32'h1;
            if (clamp)
            begin
               q_d.clamp_hit = 1'b1;
               q_d.thresh    = {DUTY_W{1'b1}};
               q_d.tmr       = '0;
               q_d.state     = BCS_SOFTSTART;
            end
            // sample and hold after test window
            else if (q_q.tmr >= 32'(OCSET_CYCLES - 1))
            begin
               // code held as-is, 0 maps to 50 mV
               q_d.thresh = ocset_level_i;
               q_d.tmr    = '0;
               q_d.state  = BCS_SOFTSTART;
            end
         end
         BCS_SOFTSTART:
         begin
            q_d.tmr = q_q.tmr + 32'h1;
            q_d.ref_v = REF_W'((64'(q_q.tmr) * 64'(REF_FULL)) / 64'(SS_CYCLES));
            if (q_q.tmr >= 32'(SS_CYCLES - 1) || (q_q.hs_started && above))
            begin
               q_d.ref_v   = REF_FULL;
               q_d.ss_done = 1'b1;
               q_d.state   = BCS_RUN;
               q_d.good    = 1'b1;
            end
         end
         BCS_RUN:
         begin
            q_d.good = in_win;
            if (uv)
            begin
               q_d.uv_trip = 1'b1;
               q_d.state   = BCS_TRIPPED;
            end
         end
         BCS_TRIPPED:
         begin
            q_d.good = 1'b0;
         end
         default:
            q_d.state = BCS_TRIPPED;
      endcase

      // ****************************************
      // dead-time phase machine
      // ****************************************
      if (q_q.state == BCS_SOFTSTART || q_q.state == BCS_RUN)
      begin
         unique case (q_q.phase)
            BCS_PH_HS_ON:
            begin
               // stale low sense from the last low-side interval must not count
               if (!ph_low)
                  q_d.ph_high = 1'b1;
               if (!hs_req)
               begin
                  q_d.phase = BCS_PH_HS_OFF_WAIT;
                  q_d.wdog  = '0;
               end
            end
            BCS_PH_HS_OFF_WAIT:
            begin
               q_d.wdog = q_q.wdog + 8'h01;
               if (!ph_low)
                  q_d.ph_high = 1'b1;
               if ((q_q.ph_high && ph_low) || q_q.wdog >= 8'(WDOG_CYC))
                  q_d.phase = BCS_PH_LS_ON;
            end
            BCS_PH_LS_ON:
               if (hs_req)
                  q_d.phase = BCS_PH_LS_OFF_WAIT;
            BCS_PH_LS_OFF_WAIT:
               if (lg_low)
               begin
                  q_d.phase      = BCS_PH_HS_ON;
                  q_d.hs_started = 1'b1;
                  q_d.ph_high    = 1'b0;
               end
            default:
               q_d.phase = BCS_PH_LS_OFF_WAIT;
         endcase
      end

      // low-side interval ends when high-side is next requested
      ls_end = (q_q.phase == BCS_PH_LS_ON) && hs_req &&
               (q_q.state == BCS_SOFTSTART || q_q.state == BCS_RUN);
      oc_now = q_q.oc_seen | (low_side_switch_o & oc1);
      q_d.oc_seen = oc_now;
      // interval straddles the period wrap, so count per interval not per period
      if (ls_end)
      begin
         q_d.oc_seen = 1'b0;
         if (!oc_now)
            q_d.oc_cnt = '0;
         else
            q_d.oc_cnt = q_q.oc_cnt + 3'h1;
      end
      if (q_q.state != BCS_OCSET &&
          ((ls_end && oc_now && q_q.oc_cnt == 3'(OC_CONSEC - 1)) ||
           (low_side_switch_o && oc2)))
      begin
         q_d.oc_trip = 1'b1;
         q_d.state   = BCS_TRIPPED;
      end

      // apb: duty write, ctrl/status/threshold/reference reads
      if (psel_i && !penable_i && !pwrite_i)
      begin
         unique case (paddr_i)
            ADDR_CTRL:   q_d.rdata = 32'(q_q.duty);
            ADDR_STATUS: q_d.rdata = 32'({q_q.clamp_hit, ~q_q.hs_started & ~q_q.ss_done,
                                          q_q.good, q_q.uv_trip, q_q.oc_trip,
                                          q_q.state != BCS_OCSET, q_q.ss_done});
            ADDR_THRESH: q_d.rdata = 32'(q_q.thresh);
            ADDR_REF:    q_d.rdata = 32'(q_q.ref_v);
            default:     q_d.rdata = 32'h0000_0000;
         endcase
      end
      if (apb_acc && pwrite_i && paddr_i == ADDR_CTRL)
         q_d.duty = pwdata_i[CTRL_DUTY_LSB +: DUTY_W];
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         q_q       <= '0;
         q_q.state <= BCS_OCSET;
         q_q.phase <= BCS_PH_LS_OFF_WAIT;
         q_q.duty  <= CTRL_DUTY_RST;
      end
      else
         q_q <= q_d;
   end

   // ****************************************
   // outputs
   // ****************************************
   always_comb
   begin
      high_side_switch_o = 1'b0;
      low_side_switch_o  = 1'b0;
      if (q_q.state == BCS_SOFTSTART || q_q.state == BCS_RUN)
      begin
         high_side_switch_o = (q_q.phase == BCS_PH_HS_ON);
         low_side_switch_o  = (q_q.phase == BCS_PH_LS_ON) &&
                              (q_q.hs_started || q_q.ss_done);
      end
   end

   assign trip_level_test_current_o = (q_q.state == BCS_OCSET);
   assign oc_threshold1_o           = q_q.thresh;
   assign oc_threshold2_o           = (DUTY_W+1)'(q_q.thresh) + (DUTY_W+1)'(q_q.thresh >> 1);
   assign soft_ref_o                = q_q.ref_v;
   assign output_good_flag_o        = q_q.good;
   assign overcurrent_trip_o        = q_q.oc_trip;
   assign output_undervolt_trip_o   = q_q.uv_trip;
   assign prdata_o                  = q_q.rdata;
   assign pready_o                  = 1'b1;
   assign pslverr_o                 = 1'b0;

endmodule : bcs_sequencer

// [hdl/bcs_pkg.sv]
// bcs_pkg: constants, register map and types for the buck control sequencer
package bcs_pkg;

   // ****************************************
   // clock and timing
   // ****************************************
   localparam int unsigned CLK_HZ           = 50_000_000;
   localparam int unsigned SW_FREQ_HZ       = 600_000;
   // one switching cycle in clock ticks, rounded down
   localparam int unsigned SW_PERIOD_CYC    = CLK_HZ / SW_FREQ_HZ;
   localparam int unsigned OCSET_TIME_US    = 5000;
   localparam int unsigned OCSET_CYC        = OCSET_TIME_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SS_TIME_US       = 4500;
   localparam int unsigned SS_CYC           = SS_TIME_US * (CLK_HZ / 1_000_000);
   localparam int unsigned WDOG_TIME_NS     = 200;
   localparam int unsigned WDOG_CYC         = (WDOG_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int unsigned OC_CONSEC        = 4;
   localparam int unsigned DUTY_W           = 8;
   localparam int unsigned REF_W            = 12;

   // ****************************************
   // apb register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_THRESH  = 8'h08;
   localparam logic [7:0] ADDR_REF     = 8'h0C;

   // ctrl fields
   localparam int unsigned CTRL_DUTY_LSB = 0;
   localparam logic [DUTY_W-1:0] CTRL_DUTY_RST = 8'h00;

   // status fields
   localparam int unsigned ST_SS_DONE   = 0;
   localparam int unsigned ST_OCSET_DN  = 1;
   localparam int unsigned ST_OC_TRIP   = 2;
   localparam int unsigned ST_UV_TRIP   = 3;
   localparam int unsigned ST_GOOD      = 4;
   localparam int unsigned ST_LS_MASK   = 5;
   localparam int unsigned ST_CLAMP     = 6;

   typedef enum logic [2:0] {
      BCS_OCSET,
      BCS_SOFTSTART,
      BCS_RUN,
      BCS_TRIPPED
   } bcs_state_t;

   typedef enum logic [2:0] {
      BCS_PH_HS_ON,
      BCS_PH_HS_OFF_WAIT,
      BCS_PH_LS_ON,
      BCS_PH_LS_OFF_WAIT
   } bcs_phase_t;

endpackage : bcs_pkg

// [tb/bcs_sequencer_sva.sv]
// bcs_sequencer_sva: port checker for the switching sequencer
`timescale 1ns/1ns
module bcs_sequencer_sva
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // sense inputs
   input wire logic phase_low_i,
   input wire logic low_gate_low_i,
   input wire logic oc_level2_i,
   // design outputs
   input wire logic trip_level_test_current_o,
   input wire logic high_side_switch_o,
   input wire logic low_side_switch_o,
   input wire logic overcurrent_trip_o,
   input wire logic output_undervolt_trip_o
);
   // ****
   // properties
   // ****
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   a_no_overlap: assert property (!(high_side_switch_o && low_side_switch_o))
      else $error("both switches on together");
   a_hs_after_gate: assert property ($rose(high_side_switch_o) |-> $past(low_gate_low_i, 2))
      else $error("high side on before low gate fell");
   // the watchdog lets the low side on without a phase drop
   a_ls_after_phase: assert property ($rose(low_side_switch_o) |->
      $past(phase_low_i, 2) || !$past(high_side_switch_o, 8)) else $error("low side on early");
   a_setting_quiet: assert property (trip_level_test_current_o |->
      !high_side_switch_o && !low_side_switch_o) else $error("switching while setting");
   a_trip_off: assert property (overcurrent_trip_o |=> !high_side_switch_o && !low_side_switch_o)
      else $error("switch on after trip");
   a_trip_latch: assert property (overcurrent_trip_o |=> overcurrent_trip_o)
      else $error("trip released without reset");
   a_uv_latch: assert property (output_undervolt_trip_o |=> output_undervolt_trip_o &&
      !high_side_switch_o && !low_side_switch_o) else $error("undervolt trip not held");
   a_level2_fast: assert property ((oc_level2_i && low_side_switch_o) [*6] |->
      ##[0:4] overcurrent_trip_o) else $error("second level did not trip");
endmodule : bcs_sequencer_sva

// [tb/bcs_power_stage_model.sv]
// bcs_power_stage_model: switch pair and sense comparators
`timescale 1ns/1ns
module bcs_power_stage_model
(
   // gate commands and knobs
   input  wire logic clk_i,
   input  wire logic hs_i,
   input  wire logic ls_i,
   input  wire logic slow_i,
   input  wire logic stuck_i,
   input  wire logic oc1_i,
   input  wire logic oc2_i,
   // sensed nodes
   output logic      phase_low_o,
   output logic      gate_low_o,
   output logic      oc_level1_o,
   output logic      oc_level2_o
);
   logic [3:0] hs_off_q = 4'hF;
   logic [3:0] ls_off_q = 4'hF;
   logic [3:0] dly;
   // ****
   // node delays
   // ****
   // unknown commands before reset count as off
   always @(posedge clk_i)
   begin
      hs_off_q <= (hs_i === 1'b1) ? 4'h0 : hs_off_q + {3'h0, hs_off_q != 4'hF};
      ls_off_q <= (ls_i === 1'b1) ? 4'h0 : ls_off_q + {3'h0, ls_off_q != 4'hF};
   end
   assign dly = slow_i ? 4'h7 : 4'h1;
   // stuck phase mimics negative inductor current
   assign phase_low_o = !stuck_i && hs_off_q >= dly;
   assign gate_low_o = ls_off_q >= dly;
   // current only seen while the low side conducts
   assign oc_level1_o = oc1_i && ls_i === 1'b1;
   assign oc_level2_o = oc2_i && ls_i === 1'b1;
endmodule : bcs_power_stage_model

// [tb/tb.sv]
// tb: self-checking bench for the buck control sequencer
`timescale 1ns/1ns
module tb;
   import bcs_pkg::*;
   logic clk_i = 1'b0, rst_b_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic clamp_i = 1'b0, uv_i = 1'b0, win_i = 1'b1, slow = 1'b0, stuck = 1'b0;
   logic oc1 = 1'b0, oc2 = 1'b0, above_i = 1'b0, early;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o, exp_q[$];
   logic pready_o, ph, gl, l1, l2, test_cur, hs, ls, good, oct, uvt;
   logic [DUTY_W-1:0] lvl_i = 8'h00, t1, duty;
   logic [DUTY_W:0] t2;
   logic [REF_W-1:0] sref;
   integer seed = 32'h58A7F697;
   int num_errors = 0, checks_done = 0, n;
   bcs_sequencer #(.OCSET_CYCLES(50), .SS_CYCLES(200)) i_bcs_sequencer
   (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(), .phase_low_i(ph), .low_gate_low_i(gl),
      .oc_level1_i(l1), .oc_level2_i(l2), .ocset_clamp_i(clamp_i), .output_undervolt_i(uv_i),
      .output_in_window_i(win_i), .output_above_ref_i(above_i), .ocset_level_i(lvl_i),
      .trip_level_test_current_o(test_cur), .oc_threshold1_o(t1), .oc_threshold2_o(t2),
      .high_side_switch_o(hs), .low_side_switch_o(ls), .soft_ref_o(sref),
      .output_good_flag_o(good), .overcurrent_trip_o(oct), .output_undervolt_trip_o(uvt)
   );
   bcs_power_stage_model i_bcs_power_stage_model
   (
      .clk_i(clk_i), .hs_i(hs), .ls_i(ls), .slow_i(slow), .stuck_i(stuck), .oc1_i(oc1),
      .oc2_i(oc2), .phase_low_o(ph), .gate_low_o(gl), .oc_level1_o(l1), .oc_level2_o(l2)
   );
   always #10 clk_i = ~clk_i;
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task results;
      if (num_errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results
   // sampled on the falling edge so outputs have settled
   task wt(input int s, input logic v, output int k);
      k = 0;
      while ((s == 0 ? ls : s == 1 ? test_cur : s == 2 ? good : s == 3 ? oct : uvt) !== v
             && k < 1000)
      begin
         @(negedge clk_i);
         k++;
      end
   endtask : wt
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      // hold the access until pready is seen high at an edge
      do
         @(posedge clk_i);
      while (pready_o !== 1'b1);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task do_reset(input logic clamp);
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      clamp_i <= clamp;
      lvl_i <= 8'h10 + 8'($random(seed) & 32'h7F);
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      duty = 8'h08 + 8'($random(seed) & 32'h1F);
      apb(1'b1, ADDR_CTRL, {24'h0, duty});
      exp_q.push_back({24'h0, duty});
      apb(1'b0, ADDR_CTRL, 32'h0);
      check("trip after reset", oct, 0);
      if (!clamp)
         wt(1, 1'b1, n);
      check("ref held", sref, 0);
      wt(1, 1'b0, n);
      check("setting length", clamp ? n < 12 : n > 30 && n < 60, 1);
      check("level one", t1, clamp ? 8'hFF : lvl_i);
      check("level two", t2, clamp ? 9'h17E : {1'b0, lvl_i} + lvl_i / 2);
      early = 1'b0;
      for (int i = 0; i < 400 && hs !== 1'b1; i++)
      begin
         @(negedge clk_i);
         early |= (ls === 1'b1);
      end
      check("low side before high side", early, 0);
      exp_q.push_back(clamp ? 32'h0000_00FF : 32'(lvl_i));
      apb(1'b0, ADDR_THRESH, 32'h0);
   endtask : do_reset
   task oc_burst(input int k);
      wt(0, 1'b0, n);
      @(posedge clk_i);
      oc1 <= 1'b1;
      repeat (k)
      begin
         wt(0, 1'b1, n);
         wt(0, 1'b0, n);
      end
      @(posedge clk_i);
      oc1 <= 1'b0;
   endtask : oc_burst
   always @(posedge clk_i)
      if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1)
         check("read data", prdata_o, exp_q.pop_front());
   initial
   begin
      #400000;
      num_errors++;
      results();
   end
   initial
   begin
      do_reset(1'b0);
      exp_q.push_back(32'h0);
      apb(1'b0, 8'h10, 32'hFFFF_FFFF);
      wt(2, 1'b1, n);
      check("good at soft start end", good, 1);
      exp_q.push_back(32'((1 << REF_W) - 1));
      apb(1'b0, ADDR_REF, 32'h0);
      @(posedge clk_i);
      win_i <= 1'b0;
      repeat (8) @(negedge clk_i);
      check("good follows window", good, 0);
      @(posedge clk_i);
      win_i <= 1'b1;
      oc_burst(3);
      repeat (200) @(negedge clk_i);
      check("three events", oct, 0);
      oc_burst(4);
      repeat (20) @(negedge clk_i);
      check("four events", oct, 1);
      check("both off", {hs, ls}, 0);
      repeat (100) @(negedge clk_i);
      check("trip held", oct, 1);
      exp_q.push_back(32'((1 << ST_SS_DONE) | (1 << ST_OCSET_DN) | (1 << ST_OC_TRIP)));
      apb(1'b0, ADDR_STATUS, 32'h0);
      @(posedge clk_i);
      slow <= 1'b1;
      stuck <= 1'b1;
      above_i <= 1'b1;
      do_reset(1'b0);
      // output already above target ends soft-start one cycle into the first high-side pulse
      wt(2, 1'b1, n);
      check("pre-charged start short", n < 100, 1);
      wt(0, 1'b1, n);
      check("watchdog low side", ls, 1);
      @(posedge clk_i);
      oc2 <= 1'b1;
      wt(3, 1'b1, n);
      check("level two trip", n < 100, 1);
      @(posedge clk_i);
      oc2 <= 1'b0;
      stuck <= 1'b0;
      above_i <= 1'b0;
      do_reset(1'b1);
      @(posedge clk_i);
      clamp_i <= 1'b0;
      uv_i <= 1'b1;
      repeat (30) @(negedge clk_i);
      check("undervolt masked", uvt, 0);
      check("reference rising", sref != 0, 1);
      @(posedge clk_i);
      uv_i <= 1'b0;
      wt(2, 1'b1, n);
      @(posedge clk_i);
      uv_i <= 1'b1;
      wt(5, 1'b1, n);
      check("undervolt trip", n < 12, 1);
      repeat (2) @(negedge clk_i);
      check("undervolt off", {hs, ls}, 0);
      results();
   end
endmodule : tb
bind bcs_sequencer bcs_sequencer_sva i_bcs_sequencer_sva
(
   .clk_i(clk_i), .rst_b_i(rst_b_i), .phase_low_i(phase_low_i), .low_gate_low_i(low_gate_low_i),
   .oc_level2_i(oc_level2_i), .trip_level_test_current_o(trip_level_test_current_o),
   .high_side_switch_o(high_side_switch_o), .low_side_switch_o(low_side_switch_o),
   .overcurrent_trip_o(overcurrent_trip_o), .output_undervolt_trip_o(output_undervolt_trip_o)
);
